// >>> design/itcs_pkg.sv
// Constants and carrier types for the clear-and-start interval timer
package itcs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ITCS_ADDR_COMPARE = 12'h000;
  localparam logic [11:0] ITCS_ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ITCS_ADDR_STATUS = 12'h008;
  localparam logic [11:0] ITCS_ADDR_MASK = 12'h00C;
  localparam int ITCS_CTL_ENABLE_BIT = 7;
  localparam int ITCS_CTL_SEL_LSB = 0;
  localparam logic [7:0] ITCS_CTL_WRITE_MASK = 8'h87;
  localparam logic [15:0] ITCS_COMPARE_RESET = 16'h0000;
  localparam logic [7:0] ITCS_CONTROL_RESET = 8'h00;
  localparam logic [15:0] ITCS_COUNT_IDLE = 16'hFFFF;
  localparam logic [15:0] ITCS_COUNT_ZERO = 16'h0000;
  localparam int ITCS_STAT_MATCH_BIT = 0;
  localparam logic [31:0] ITCS_ERR_NONE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } itcs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } itcs_apb_rsp_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } itcs_div_state_t;
endpackage : itcs_pkg

// >>> design/itcs_prescaler.sv
// Count clock prescaler: one tick per 2**sel peripheral clocks
`timescale 1ns/1ps
`default_nettype none
module itcs_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  itcs_pkg::itcs_div_state_t s_q, s_d;
  logic [6:0] limit;

  always_comb begin
    limit = 7'((8'h01 << sel) - 8'h01);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = 7'h00;
    end else if (s_q.cnt >= limit) begin
      s_d.cnt = 7'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : itcs_prescaler
`default_nettype wire

// >>> design/itcs_timer.sv
// Interval timer top: APB registers, counter, match interrupt
`timescale 1ns/1ps
`default_nettype none
module itcs_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire itcs_pkg::itcs_apb_req_t apb_req,
  output itcs_pkg::itcs_apb_rsp_t apb_rsp,
  output logic interval_match_irq,
  output logic irq
);
  typedef struct packed {
    logic [15:0] interval_compare_value;
    logic [7:0] timer_control_byte;
    logic [15:0] count;
    logic match_status;
    logic match_mask;
    logic match_pulse;
    logic started;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } itcs_state_t;

  itcs_state_t s_q, s_d;
  logic count_tick;
  logic count_enable_bit;
  logic access;
  logic wr;
  logic match_now;

  assign count_enable_bit = s_q.timer_control_byte[itcs_pkg::ITCS_CTL_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  itcs_prescaler u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(count_enable_bit),
    .sel(s_q.timer_control_byte[itcs_pkg::ITCS_CTL_SEL_LSB +: 3]),
    .tick(count_tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    access = apb_req.psel && apb_req.penable;
    wr = access && apb_req.pwrite;
    match_now = count_tick && (s_q.count == s_q.interval_compare_value);
    s_d.match_pulse = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // Counter; started marks that the first tick after enable has passed
    if (!count_enable_bit) begin
      s_d.count = itcs_pkg::ITCS_COUNT_IDLE;
      s_d.started = 1'b0;
    end else if (count_tick) begin
      s_d.started = 1'b1;
    end
    if (!count_enable_bit) begin
      s_d.count = itcs_pkg::ITCS_COUNT_IDLE;
    end else if (count_tick) begin
      if (s_q.count == itcs_pkg::ITCS_COUNT_IDLE) begin
        s_d.count = itcs_pkg::ITCS_COUNT_ZERO;
      end else if (match_now) begin
        s_d.count = itcs_pkg::ITCS_COUNT_ZERO;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end

    // Match on FFFF with compare FFFF, but not the idle FFFF before start
    if (count_enable_bit && match_now && s_q.started) begin
      s_d.match_pulse = 1'b1;
    end

    // Register bus, one wait state
    if (access && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        itcs_pkg::ITCS_ADDR_COMPARE: begin
          s_d.prdata = {16'h0000, s_q.interval_compare_value};
          if (wr) begin
            s_d.interval_compare_value = apb_req.pwdata[15:0];
          end
        end
        itcs_pkg::ITCS_ADDR_CONTROL: begin
          s_d.prdata = {24'h00_0000, s_q.timer_control_byte};
          if (wr) begin
            s_d.timer_control_byte = apb_req.pwdata[7:0] & itcs_pkg::ITCS_CTL_WRITE_MASK;
          end
        end
        itcs_pkg::ITCS_ADDR_STATUS: begin
          s_d.prdata = {31'h0000_0000, s_q.match_status};
          if (wr && apb_req.pwdata[itcs_pkg::ITCS_STAT_MATCH_BIT]) begin
            s_d.match_status = 1'b0;
          end
        end
        itcs_pkg::ITCS_ADDR_MASK: begin
          s_d.prdata = {31'h0000_0000, s_q.match_mask};
          if (wr) begin
            s_d.match_mask = apb_req.pwdata[itcs_pkg::ITCS_STAT_MATCH_BIT];
          end
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // Set wins over clear
    if (s_d.match_pulse) begin
      s_d.match_status = 1'b1;
    end
    s_d.irq = s_d.match_status && s_d.match_mask;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.count <= itcs_pkg::ITCS_COUNT_IDLE;
      s_q.interval_compare_value <= itcs_pkg::ITCS_COMPARE_RESET;
      s_q.timer_control_byte <= itcs_pkg::ITCS_CONTROL_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign apb_rsp.prdata = s_q.prdata;
  assign apb_rsp.pready = s_q.pready;
  assign apb_rsp.pslverr = s_q.pslverr;
  assign interval_match_irq = s_q.match_pulse;
  assign irq = s_q.irq;
endmodule : itcs_timer
`default_nettype wire

// >>> bench/itcs_timer_monitor.sv
// Port checks for the interval timer
`timescale 1ns/1ps
`default_nettype none
module itcs_timer_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire itcs_pkg::itcs_apb_req_t apb_req,
  input wire itcs_pkg::itcs_apb_rsp_t apb_rsp,
  input wire logic interval_match_irq,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = apb_req.psel && apb_req.penable && clk_en;
  wire logic rdy = apb_rsp.pready;
  wire logic err = apb_rsp.pslverr;
  wire logic mi = interval_match_irq;
  a_wait_one: assert property (acc && !rdy |=> rdy) else $error("no answer");
  a_ready_once: assert property (rdy |=> !rdy) else $error("long ready");
  a_ready_cause: assert property (rdy |-> $past(acc)) else $error("stray ready");
  a_err_ready: assert property (err |-> rdy) else $error("stray error");
  a_err_zero:
    assert property (err && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0) else $error("err data");
  a_map_err:
    assert property (rdy |-> err == !(apb_req.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("map error");
  a_irq_rise:
    assert property ($rose(irq) |-> mi || rdy) else $error("irq");
  a_irq_fall: assert property ($fell(irq) |-> rdy) else $error("drop");
  c_match: cover property (mi);
  c_irq: cover property ($rose(irq));
  c_err: cover property (err);
endmodule : itcs_timer_monitor
bind itcs_timer itcs_timer_monitor u_mon (.clk, .rst_n, .clk_en, .apb_req, .apb_rsp,
  .interval_match_irq, .irq);
`default_nettype wire

// >>> bench/itcs_timer_tb.sv
// Self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
module itcs_timer_tb;
  logic clk, rst_n, mi, irq;
  itcs_pkg::itcs_apb_req_t rq;
  itcs_pkg::itcs_apb_rsp_t rs;
  int err_total, n_tests, n;
  itcs_timer dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .apb_req(rq), .apb_rsp(rs),
    .interval_match_irq(mi), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Setup, then access held until pready is seen high
  task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic [31:0] e, logic er = 0);
    int k;
    @(posedge clk);
    rq <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    rq.penable <= 1'b1;
    for (k = 0; k < 50 && rs.pready !== 1'b1; k++) @(negedge clk);
    chk("ready", 1, k < 50);
    if (k == 50) results();
    if (!w) chk("rdata", e, rs.prdata);
    chk("slverr", er, rs.pslverr);
    @(posedge clk);
    rq <= '0;
  endtask : apb
  task automatic gap;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mi !== 1'b1 && n < 3000);
    chk("pulse", 1, n < 3000);
    if (n == 3000) results();
  endtask : gap
  initial begin
    rq = '0;
    rst_n = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(12'h004, 1, 32'h78, 0);
    apb(12'h004, 0, 0, 0);
    apb(12'h010, 0, 0, 0, 1);
    for (int s = 7; s >= 0; s--) begin
      apb(12'h004, 1, 0, 0);
      apb(12'h000, 1, s, 0);
      apb(12'h004, 1, 32'h80 | s, 0);
      gap();
      chk("first", 1, n > ((s + 1) << s));
      gap();
      chk("period", (s + 1) << s, n);
    end
    apb(12'h004, 1, 0, 0);
    apb(12'h000, 1, 32'hFFFF, 0);
    apb(12'h004, 1, 32'h80, 0);
    repeat (20) @(negedge clk) chk("idle wrap", 0, mi);
    apb(12'h004, 1, 0, 0);
    repeat (2) @(negedge clk);
    repeat (20) @(negedge clk) chk("stopped", 0, mi);
    chk("irq", 0, irq);
    apb(12'h008, 0, 0, 1);
    apb(12'h00C, 1, 1, 0);
    repeat (2) @(negedge clk);
    chk("irq", 1, irq);
    apb(12'h008, 1, 1, 0);
    repeat (2) @(negedge clk);
    chk("irq", 0, irq);
    results();
  end
endmodule : itcs_timer_tb
`default_nettype wire
